/* src/realign_pkg.sv */
package realign_pkg;
  // Serial word layout
  localparam int WORD_W       = 24;
  localparam int SEL_LSB      = 0;
  localparam int SEL_W        = 2;
  localparam int LOAD_SEL_BIT = 23;
  localparam int DEN_LSB      = 3;
  localparam int DEN_W        = 11;
  localparam int MULT_LSB     = 12;
  localparam int MULT_W       = 4;
  localparam int PERIOD_W     = DEN_W + MULT_W;
  localparam logic [1:0] SEL_FIRST  = 2'h0;
  localparam logic [1:0] SEL_SECOND = 2'h1;
  localparam logic [1:0] SEL_THIRD  = 2'h2;
  // Sync pulses seen after a frequency load before realigning
  localparam logic [1:0] REALIGN_PULSES = 2'h2;
  // Reset values
  localparam logic [DEN_W-1:0]  DEN_RST  = 11'h000;
  localparam logic [MULT_W-1:0] MULT_RST = 4'h0;
  localparam logic [31:0]       CTRL_RST = 32'h0000_0001;
  // Wishbone byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_SECOND   = 8'h08;
  localparam logic [7:0] OFS_THIRD    = 8'h0c;
  localparam logic [7:0] OFS_FIRST    = 8'h10;
  localparam logic [7:0] OFS_COUNT    = 8'h14;
  localparam logic [7:0] OFS_SETTINGS = 8'h18;
  // Field positions
  localparam int CTRL_PORT_EN   = 0;
  localparam int ST_ENABLED     = 0;
  localparam int ST_SYNC_SEEN   = 1;
  localparam int ST_REALIGN_SEEN = 2;
  localparam int ST_PEND_LSB    = 4;
endpackage

/* src/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             i_clock,   // System clock
  input  wire logic             i_resetn,  // Synchronous reset, active low
  input  wire logic [WIDTH-1:0] i_async,   // Pins from outside the domain
  output logic      [WIDTH-1:0] o_sync     // Two-flop synchronised copy
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] hold_r;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
          meta_r[g] <= 1'b0;
          hold_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= i_async[g];
          hold_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign o_sync = hold_r;
endmodule // pin_sync

/* src/serial_load_phase_realign_timer.sv */
`timescale 1ns/10ps
// Contract
// (RULE1) Sync period is multiplier times interval cycles
// (RULE2) Multiplier is third word bits 15..12
// (RULE3) Multiplier zero disables all sync pulses
// (RULE4) Host makes interval a denominator multiple
// (RULE5) Load-select bit set stores interval count
// (RULE6) Realign on second sync after strobe
// (RULE7) Host keeps sync period above lock time
// (RULE8) Shift on clock rise, latch on strobe
// (RULE9) Host serial clock at most 20 MHz
// (RULE10) Host sends three bytes, then raises strobe
// (RULE11) Host uses clock phase zero as master
// (RULE12) Host keeps denominator within 2..4095; the 11-bit field holds at most 2047
// (RULE13) Timer advances once per comparator cycle
// (RULE14) Words arrive most significant bit first
// (RULE15) Timer restarts from zero after each pulse
module serial_load_phase_realign_timer
  import realign_pkg::*;
(
  input  wire logic        i_clock,          // 25 MHz system clock
  input  wire logic        i_resetn,         // Synchronous reset, low
  input  wire logic        i_serial_clock,   // Serial clock pin
  input  wire logic        i_serial_data,    // Serial data pin
  input  wire logic        i_latch_strobe,   // Latch strobe pin
  input  wire logic        i_compare_ref,    // Comparator reference pin
  output logic             o_sync_pulse,     // One-cycle sync pulse
  output logic             o_phase_realign,  // One-cycle realign pulse
  input  wire logic        i_wb_cyc,         // Wishbone cycle
  input  wire logic        i_wb_stb,         // Wishbone strobe
  input  wire logic        i_wb_we,          // Wishbone write enable
  input  wire logic [7:0]  i_wb_adr,         // Wishbone byte address
  input  wire logic [3:0]  i_wb_sel,         // Wishbone byte lanes
  input  wire logic [31:0] i_wb_dat,         // Wishbone write data
  output logic      [31:0] o_wb_dat,         // Wishbone read data
  output logic             o_wb_ack          // Wishbone acknowledge
);
  import realign_pkg::*;

  logic [2:0]          pins_s;
  logic                sclk_d_r;
  logic                le_d_r;
  logic                ref_d_r;
  logic                sclk_rise;
  logic                le_rise;
  logic                ref_edge;
  logic                data_s;
  logic [WORD_W-1:0]   shift_r;
  logic [WORD_W-1:0]   first_word_r;
  logic [WORD_W-1:0]   second_word_r;
  logic [WORD_W-1:0]   third_word_r;
  logic [DEN_W-1:0]    fraction_denominator_r;
  logic [DEN_W-1:0]    interval_r;
  logic [MULT_W-1:0]   mult_r;
  logic [PERIOD_W-1:0] period;
  logic [PERIOD_W-1:0] count_r;
  logic                sync_nxt;
  logic [1:0]          pend_r;
  logic [31:0]         ctrl_r;
  logic                sync_seen_r;
  logic                realign_seen_r;
  logic                port_en;
  logic                wb_req;
  logic                wb_wr;
  logic [SEL_W-1:0]    sel_field;

  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_async  ({i_compare_ref, ~i_latch_strobe, i_serial_clock}),
    .o_sync   (pins_s)
  );

  // Second flop of the data pin lines up with the clock pin's copy
  logic data_m_r;
  logic data_r;
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      data_m_r <= 1'b0;
      data_r   <= 1'b0;
    end else begin
      data_m_r <= i_serial_data;
      data_r   <= data_m_r;
    end
  end
  assign data_s = data_r;

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      sclk_d_r <= 1'b0;
      le_d_r   <= 1'b0;
      ref_d_r  <= 1'b0;
    end else begin
      sclk_d_r <= pins_s[0];
      le_d_r   <= pins_s[1];
      ref_d_r  <= pins_s[2];
    end
  end

  assign port_en   = ctrl_r[CTRL_PORT_EN];
  assign sclk_rise = port_en && pins_s[0] && !sclk_d_r;
  // Strobe idles high, so its copy is inverted to match the reset value
  assign le_rise   = port_en && !pins_s[1] && le_d_r;
  assign ref_edge  = pins_s[2] && !ref_d_r;
  assign sel_field = shift_r[SEL_LSB +: SEL_W];

  // (RULE8) shift on rise
  // (RULE14) MSB first
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      shift_r <= '0;
    end else if (sclk_rise) begin
      shift_r <= {shift_r[WORD_W-2:0], data_s};
    end
  end

  // (RULE8) strobe transfers word
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      first_word_r  <= '0;
      second_word_r <= '0;
      third_word_r  <= '0;
    end else if (le_rise) begin
      case (sel_field)
        SEL_FIRST:  first_word_r  <= shift_r;
        SEL_SECOND: second_word_r <= shift_r;
        SEL_THIRD:  third_word_r  <= shift_r;
        default:    first_word_r  <= first_word_r;
      endcase
    end
  end

  // (RULE5) interval or denominator
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      fraction_denominator_r <= DEN_RST;
      interval_r             <= DEN_RST;
    end else if (le_rise && sel_field == SEL_SECOND) begin
      if (shift_r[LOAD_SEL_BIT]) begin
        interval_r <= shift_r[DEN_LSB +: DEN_W];
      end else begin
        fraction_denominator_r <= shift_r[DEN_LSB +: DEN_W];
      end
    end
  end

  // (RULE2) multiplier field
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      mult_r <= MULT_RST;
    end else if (le_rise && sel_field == SEL_THIRD) begin
      mult_r <= shift_r[MULT_LSB +: MULT_W];
    end
  end

  // (RULE1) period product
  assign period = PERIOD_W'(mult_r) * PERIOD_W'(interval_r);

  // (RULE3) zero multiplier disables
  assign sync_nxt = ref_edge && mult_r != '0 && period != '0
                    && count_r == period - PERIOD_W'(1);

  // (RULE13) one step per cycle
  // (RULE15) restart after pulse
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      count_r <= '0;
    end else if (ref_edge) begin
      if (mult_r == '0 || sync_nxt || count_r >= period) begin
        count_r <= '0;
      end else begin
        count_r <= count_r + PERIOD_W'(1);
      end
    end
  end

  // (RULE6) second pulse realigns
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      pend_r <= 2'h0;
    end else if (le_rise && sel_field == SEL_FIRST) begin
      pend_r <= REALIGN_PULSES;
    end else if (sync_nxt && pend_r != 2'h0) begin
      pend_r <= pend_r - 2'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_sync_pulse    <= 1'b0;
      o_phase_realign <= 1'b0;
    end else begin
      o_sync_pulse    <= sync_nxt;
      o_phase_realign <= sync_nxt && pend_r == 2'h1
                         && !(le_rise && sel_field == SEL_FIRST);
    end
  end

  // Wishbone slave: one wait state, ack for one cycle
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wb_wr  = wb_req && i_wb_we;

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wb_wr && i_wb_adr == OFS_CTRL && i_wb_sel[0]) begin
      ctrl_r <= {31'h0, i_wb_dat[CTRL_PORT_EN]};
    end
  end

  // Sticky flags: hardware set wins over write-one clear
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      sync_seen_r    <= 1'b0;
      realign_seen_r <= 1'b0;
    end else begin
      if (o_sync_pulse) begin
        sync_seen_r <= 1'b1;
      end else if (wb_wr && i_wb_adr == OFS_STATUS && i_wb_sel[0]
                   && i_wb_dat[ST_SYNC_SEEN]) begin
        sync_seen_r <= 1'b0;
      end
      if (o_phase_realign) begin
        realign_seen_r <= 1'b1;
      end else if (wb_wr && i_wb_adr == OFS_STATUS && i_wb_sel[0]
                   && i_wb_dat[ST_REALIGN_SEEN]) begin
        realign_seen_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= '0;
      if (wb_req && !i_wb_we) begin
        case (i_wb_adr)
          OFS_CTRL:     o_wb_dat <= ctrl_r;
          OFS_STATUS:   o_wb_dat <= {26'h0, pend_r, 1'b0,
                                     realign_seen_r, sync_seen_r,
                                     mult_r != '0};
          OFS_SECOND:   o_wb_dat <= {8'h0, second_word_r};
          OFS_THIRD:    o_wb_dat <= {8'h0, third_word_r};
          OFS_FIRST:    o_wb_dat <= {8'h0, first_word_r};
          OFS_COUNT:    o_wb_dat <= {17'h0, count_r};
          OFS_SETTINGS: o_wb_dat <= {5'h0, fraction_denominator_r,
                                     1'b0, interval_r, mult_r};
          default:      o_wb_dat <= '0;
        endcase
      end
    end
  end

  AST_SYNC_PERIOD: assert property ( // RULE1
    @(posedge i_clock) disable iff (!i_resetn)
    o_sync_pulse |-> $past(count_r) == $past(period) - PERIOD_W'(1)
                     && $past(ref_edge))
    else $error("sync pulse off its period");

  AST_MULT_FIELD: assert property ( // RULE2
    @(posedge i_clock) disable iff (!i_resetn)
    (le_rise && sel_field == SEL_THIRD)
      |=> mult_r == $past(shift_r[15:12]))
    else $error("multiplier not taken from bits 15..12");

  AST_DISABLED: assert property ( // RULE3
    @(posedge i_clock) disable iff (!i_resetn)
    ($past(mult_r) == '0) |-> !o_sync_pulse && !o_phase_realign)
    else $error("sync pulse while disabled");

  AST_INTERVAL: assert property ( // RULE5
    @(posedge i_clock) disable iff (!i_resetn)
    (le_rise && sel_field == SEL_SECOND && shift_r[23])
      |=> interval_r == $past(shift_r[13:3]))
    else $error("interval count not stored");

  AST_REALIGN: assert property ( // RULE6
    @(posedge i_clock) disable iff (!i_resetn)
    o_phase_realign |-> o_sync_pulse && $past(pend_r) == 2'h1)
    else $error("realign not on second sync pulse");

  AST_SHIFT: assert property ( // RULE8
    @(posedge i_clock) disable iff (!i_resetn)
    sclk_rise |=> shift_r == {$past(shift_r[22:0]), $past(data_s)})
    else $error("serial bit not shifted in");

  AST_COUNT_EDGE: assert property ( // RULE13
    @(posedge i_clock) disable iff (!i_resetn)
    !ref_edge |=> $stable(count_r))
    else $error("timer moved without a comparator edge");

  AST_RESTART: assert property ( // RULE15
    @(posedge i_clock) disable iff (!i_resetn)
    o_sync_pulse |-> count_r == '0 ##1 count_r <= PERIOD_W'(1))
    else $error("timer did not restart after pulse");
endmodule // serial_load_phase_realign_timer

/* sim/serial_host.sv */
`timescale 1ns/10ps
module serial_host (
  input  wire logic i_clock,         // System clock
  output logic      o_serial_clock,  // Serial clock pin
  output logic      o_serial_data,   // Serial data pin
  output logic      o_latch_strobe   // Latch strobe pin
);
  initial begin
    o_serial_clock = 1'b0;
    o_serial_data  = 1'b0;
    o_latch_strobe = 1'b1;
  end
  // 320 ns clock, data set while low
  task automatic send(input logic [23:0] word);
    @(posedge i_clock);
    o_latch_strobe <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      o_serial_data <= word[i];
      repeat (4) @(posedge i_clock);
      o_serial_clock <= 1'b1;
      repeat (4) @(posedge i_clock);
      o_serial_clock <= 1'b0;
    end
    repeat (4) @(posedge i_clock);
    o_latch_strobe <= 1'b1;
    o_serial_data  <= ~word[0];
    @(posedge i_clock);
  endtask
endmodule // serial_host

/* sim/test_serial_load_phase_realign_timer.sv */
`timescale 1ns/10ps
module test_serial_load_phase_realign_timer;
  import realign_pkg::*;
  logic        clock;
  logic        resetn;
  logic        sclk;
  logic        sdat;
  logic        strobe;
  logic        ref_on;
  logic [2:0]  ref_cnt;
  logic        sync_pulse;
  logic        realign;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [3:0]  mu;
  logic [10:0] iv;
  int          fails;
  int          n_checks;
  int          n_sync;
  int          n;

  serial_load_phase_realign_timer dut (
    .i_clock(clock), .i_resetn(resetn), .i_serial_clock(sclk),
    .i_serial_data(sdat), .i_latch_strobe(strobe),
    .i_compare_ref(ref_cnt[2]), .o_sync_pulse(sync_pulse),
    .o_phase_realign(realign), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack));

  serial_host host (
    .i_clock(clock), .o_serial_clock(sclk), .o_serial_data(sdat),
    .o_latch_strobe(strobe));

  always #20 clock = ~clock;

  // Reference runs at one eighth of the system clock while enabled
  always @(posedge clock) begin
    if (ref_on) ref_cnt <= ref_cnt + 3'h1;
    if (sync_pulse === 1'b1) n_sync <= n_sync + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] dw, output logic [31:0] dr);
    int t;
    t = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= dw;
    do begin
      @(posedge clock);
      t++;
    end while (ack !== 1'b1 && t < 100);
    if (ack !== 1'b1) fails++;
    dr = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dw);
    logic [31:0] x;
    wb(1'b1, a, dw, x);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    wb(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask

  task automatic wait_sync(output int c);
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (sync_pulse !== 1'b1 && c < 2000);
    if (sync_pulse !== 1'b1) fails++;
  endtask

  function automatic logic [31:0] settings(logic [3:0] m, logic [10:0] i,
                                           logic [10:0] dn);
    return {5'h00, dn, 1'b0, i, m};
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    test_done;
  end

  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    ref_on = 1'b0;
    ref_cnt = 3'h0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
    n_sync = 0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(OFS_CTRL, CTRL_RST);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_SETTINGS, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0);
    $display("test reset_map done");
    host.send({1'b0, 9'h000, 11'h002, 1'b0, 2'h1});
    host.send({1'b1, 9'h000, 11'h004, 1'b0, 2'h1});
    repeat (8) @(posedge clock);
    rd(OFS_SETTINGS, settings(4'h0, 11'h004, 11'h002));
    n = n_sync;
    ref_on <= 1'b1;
    repeat (400) @(posedge clock);
    chk(n_sync - n, 32'h0);
    $display("test load_disabled done");
    for (int k = 0; k < 2; k++) begin
      mu = (k == 0) ? 4'h3 : 4'hf;
      iv = (k == 0) ? 11'h004 : 11'h002;
      ref_on <= 1'b0;
      host.send({1'b1, 9'h000, iv, 1'b0, 2'h1});
      host.send({8'h00, mu, 10'h000, 2'h2});
      repeat (8) @(posedge clock);
      rd(OFS_SETTINGS, settings(mu, iv, 11'h002));
      ref_on <= 1'b1;
      wait_sync(n);
      wait_sync(n);
      chk(n, mu * iv * 8);
    end
    $display("test period done");
    ref_on <= 1'b0;
    host.send(24'h12_3450);
    repeat (8) @(posedge clock);
    ref_on <= 1'b1;
    wait_sync(n);
    chk({31'h0, realign}, 32'h0);
    wait_sync(n);
    chk({31'h0, realign}, 32'h1);
    ref_on <= 1'b0;
    rd(OFS_STATUS, 32'h7);
    wr(OFS_STATUS, 32'h6);
    rd(OFS_STATUS, 32'h1);
    rd(OFS_FIRST, 32'h0012_3450);
    rd(OFS_COUNT, 32'h0);
    $display("test realign done");
    wr(OFS_CTRL, 32'h0);
    host.send({8'h00, 4'h5, 10'h000, 2'h2});
    wr(OFS_CTRL, 32'h1);
    host.send({8'h00, 4'h5, 10'h000, 2'h3});
    repeat (8) @(posedge clock);
    rd(OFS_SETTINGS, settings(4'hf, 11'h002, 11'h002));
    rd(OFS_CTRL, 32'h1);
    rd(OFS_THIRD, 32'h0000_f002);
    rd(OFS_SECOND, 32'h0080_0011);
    $display("test refused done");
    test_done;
  end
endmodule // test_serial_load_phase_realign_timer
